// ---- hdl/afsc_link_if.sv ----
// carrier between the serial receiver and the register bank
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface afsc_link_if;
    logic        sclk_rise;
    logic        strobe_rise;
    logic [15:0] frame;
    logic [1:0]  strap;

    modport rx   (output sclk_rise, output strobe_rise, output frame,
                  output strap);
    modport bank (input sclk_rise, input strobe_rise, input frame,
                  input strap);
endinterface : afsc_link_if

// ---- hdl/afsc_pkg.sv ----
// constants of the serial control register bank
// assumes one system clock; serial pins are asynchronous to it
package afsc_pkg;
    localparam int FRAME_W   = 16;
    localparam int DATA_W    = 10;
    localparam int SYNC_LEN  = 3;
    localparam int READ_BITS = 10;

    // frame field positions, most significant bit sent first
    localparam int CHIP_HI   = 15;
    localparam int CHIP_LO   = 14;
    localparam int READ_BIT  = 13;
    localparam int ADDR_HI   = 12;
    localparam int ADDR_LO   = 10;

    localparam logic [2:0] ADDR_CONFIG  = 3'h0;
    localparam logic [2:0] ADDR_STANDBY = 3'h1;
    localparam logic [2:0] ADDR_EGAIN   = 3'h2;
    localparam logic [2:0] ADDR_OGAIN   = 3'h3;
    localparam logic [2:0] ADDR_ECLAMP  = 3'h4;
    localparam logic [2:0] ADDR_OCLAMP  = 3'h5;
    localparam logic [2:0] ADDR_TEST    = 3'h6;
    localparam logic [2:0] ADDR_PROBE   = 3'h7;

    // field positions inside the 10-bit data word
    localparam int STANDBY_POS  = 0;
    localparam int EDGE2_LO     = 2;
    localparam int EDGE1_LO     = 6;
    localparam int TEST_EN_POS  = 0;
    localparam int PATTERN_POS  = 2;
    localparam int INTERVAL_LO  = 4;
    localparam int PROBE_POS    = 1;

    // values after reset, and the readback count load
    localparam logic       STANDBY_RST  = 1'b0;
    localparam logic [3:0] EDGE2_RST    = 4'h8;
    localparam logic [3:0] EDGE1_RST    = 4'h8;
    localparam logic [9:0] GAIN_RST     = 10'h040;
    localparam logic [7:0] CLAMP_RST    = 8'h50;
    localparam logic       TEST_EN_RST  = 1'b0;
    localparam logic       PATTERN_RST  = 1'b0;
    localparam logic [1:0] INTERVAL_RST = 2'h0;
    localparam logic       PROBE_RST    = 1'b0;
    localparam logic [3:0] READ_CNT_RST = 4'h0;
    localparam logic [3:0] READ_CNT_LD  = 4'hA;
endpackage : afsc_pkg

// ---- hdl/afsc_regs.sv ----
// serial control register bank of the dual-channel front end
// assumes serial pins and straps arrive asynchronously; the adc bit
// and converter clock sample on clk_sys
`timescale 1ns/1ps

// How it works
// - reg 01h bit 0: standby, reset normal
// - reg 01h bits 5:2: second edge delay
// - reg 01h bits 9:6: first edge delay
// - probe bit routes converter clock onto bit zero
// - reg 02h even gain, code over 64
// - reg 03h odd gain, same scaling
// - reg 04h even clamp, default 50h
// - reg 05h odd clamp, default 50h
// - reg 06h bit 0 test enable, off
// - reg 06h bit 2 pattern select
// - reg 06h bits 5:4 pattern interval
// - readback address in frame bits 12:10
// - 16-bit frame: chip, address, data
// - shift on clock rise, latch on strobe
// - ignore frames for other chip address
// - readback blocks writes, shifts data out
module afsc_regs (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       sclk,
    input  wire logic       serial_in,
    input  wire logic       write_strobe,
    input  wire logic       chip_select_strap_low,
    input  wire logic       chip_select_strap_high,
    input  wire logic       adc_bit_zero,
    input  wire logic       converter_clock,
    output logic            serial_read_out,
    output logic            standby_select,
    output logic [3:0]      edge2_delay,
    output logic [3:0]      edge1_delay,
    output logic [9:0]      even_gain,
    output logic [9:0]      odd_gain,
    output logic [7:0]      even_black_clamp,
    output logic [7:0]      odd_black_clamp,
    output logic            test_enable,
    output logic            pattern_select,
    output logic [1:0]      pattern_interval,
    output logic            converter_clock_probe_enable,
    output logic            output_bit_zero,
    output logic            read_busy
);
    afsc_link_if link ();

    logic       chip_match;
    logic       is_read;
    logic [2:0] reg_addr;
    logic [9:0] wdata;
    logic       write_ok;
    logic       read_ok;
    logic [9:0] read_word;
    logic [8:0] read_shift;
    logic [3:0] read_cnt;

    afsc_serial_rx u_rx (
        .clk_sys                (clk_sys),
        .rst                    (rst),
        .sclk                   (sclk),
        .serial_in              (serial_in),
        .write_strobe           (write_strobe),
        .chip_select_strap_low  (chip_select_strap_low),
        .chip_select_strap_high (chip_select_strap_high),
        .link                   (link.rx)
    );

    assign chip_match = link.frame[afsc_pkg::CHIP_HI:afsc_pkg::CHIP_LO]
                        == link.strap;
    assign is_read    = link.frame[afsc_pkg::READ_BIT];
    assign reg_addr   = link.frame[afsc_pkg::ADDR_HI:afsc_pkg::ADDR_LO];
    assign wdata      = link.frame[afsc_pkg::DATA_W-1:0];
    // a strobe while data is still going out would corrupt the readback
    assign write_ok   = link.strobe_rise && chip_match && !is_read
                        && !read_busy;
    assign read_ok    = link.strobe_rise && chip_match && is_read
                        && !read_busy;

    // unused and configuration bits read back as zero
    always_comb begin
        read_word = 10'h000;
        case (reg_addr)
            afsc_pkg::ADDR_STANDBY: begin
                read_word[afsc_pkg::STANDBY_POS] = standby_select;
                read_word[afsc_pkg::EDGE2_LO +: 4] = edge2_delay;
                read_word[afsc_pkg::EDGE1_LO +: 4] = edge1_delay;
            end
            afsc_pkg::ADDR_EGAIN: begin
                read_word = even_gain;
            end
            afsc_pkg::ADDR_OGAIN: begin
                read_word = odd_gain;
            end
            afsc_pkg::ADDR_ECLAMP: begin
                read_word[7:0] = even_black_clamp;
            end
            afsc_pkg::ADDR_OCLAMP: begin
                read_word[7:0] = odd_black_clamp;
            end
            afsc_pkg::ADDR_TEST: begin
                read_word[afsc_pkg::TEST_EN_POS] = test_enable;
                read_word[afsc_pkg::PATTERN_POS] = pattern_select;
                read_word[afsc_pkg::INTERVAL_LO +: 2] = pattern_interval;
            end
            afsc_pkg::ADDR_PROBE: begin
                read_word[afsc_pkg::PROBE_POS] =
                    converter_clock_probe_enable;
            end
            default: begin
                read_word = 10'h000;
            end
        endcase
    end

    // standby and multiplex edge delays
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            standby_select <= afsc_pkg::STANDBY_RST;
            edge2_delay    <= afsc_pkg::EDGE2_RST;
            edge1_delay    <= afsc_pkg::EDGE1_RST;
        end else if (write_ok && reg_addr == afsc_pkg::ADDR_STANDBY) begin
            standby_select <= wdata[afsc_pkg::STANDBY_POS];
            edge2_delay    <= wdata[afsc_pkg::EDGE2_LO +: 4];
            // no ordering check: keeping edge 1 before edge 2 is up to
            // the host
            edge1_delay    <= wdata[afsc_pkg::EDGE1_LO +: 4];
        end
    end

    // per-channel gain
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            even_gain <= afsc_pkg::GAIN_RST;
            odd_gain  <= afsc_pkg::GAIN_RST;
        end else if (write_ok) begin
            if (reg_addr == afsc_pkg::ADDR_EGAIN) begin
                even_gain <= wdata;
            end
            if (reg_addr == afsc_pkg::ADDR_OGAIN) begin
                odd_gain <= wdata;
            end
        end
    end

    // per-channel black clamp; top two data bits are fixed zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            even_black_clamp <= afsc_pkg::CLAMP_RST;
            odd_black_clamp  <= afsc_pkg::CLAMP_RST;
        end else if (write_ok) begin
            if (reg_addr == afsc_pkg::ADDR_ECLAMP) begin
                even_black_clamp <= wdata[7:0];
            end
            if (reg_addr == afsc_pkg::ADDR_OCLAMP) begin
                odd_black_clamp <= wdata[7:0];
            end
        end
    end

    // test pattern control
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            test_enable      <= afsc_pkg::TEST_EN_RST;
            pattern_select   <= afsc_pkg::PATTERN_RST;
            pattern_interval <= afsc_pkg::INTERVAL_RST;
        end else if (write_ok && reg_addr == afsc_pkg::ADDR_TEST) begin
            test_enable      <= wdata[afsc_pkg::TEST_EN_POS];
            pattern_select   <= wdata[afsc_pkg::PATTERN_POS];
            pattern_interval <= wdata[afsc_pkg::INTERVAL_LO +: 2];
        end
    end

    // converter clock probe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            converter_clock_probe_enable <= afsc_pkg::PROBE_RST;
        end else if (write_ok && reg_addr == afsc_pkg::ADDR_PROBE) begin
            converter_clock_probe_enable <= wdata[afsc_pkg::PROBE_POS];
        end
    end

    // registered mux: the probed clock is a sampled copy, so it only
    // shows edges the system clock can resolve
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            output_bit_zero <= 1'b0;
        end else if (converter_clock_probe_enable) begin
            output_bit_zero <= converter_clock;
        end else begin
            output_bit_zero <= adc_bit_zero;
        end
    end

    // readback: msb shows at the strobe, next bit on every clock rise
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            read_cnt        <= afsc_pkg::READ_CNT_RST;
            read_busy       <= 1'b0;
            read_shift      <= 9'h000;
            serial_read_out <= 1'b0;
        end else if (read_ok) begin
            read_cnt        <= afsc_pkg::READ_CNT_LD;
            read_busy       <= 1'b1;
            serial_read_out <= read_word[9];
            read_shift      <= read_word[8:0];
        end else if (read_busy && link.sclk_rise) begin
            read_cnt        <= read_cnt - 4'h1;
            read_busy       <= (read_cnt != 4'h1);
            serial_read_out <= read_shift[8];
            read_shift      <= {read_shift[7:0], 1'b0};
        end
    end
endmodule : afsc_regs

// ---- hdl/afsc_serial_rx.sv ----
// synchronisers for the serial pins and the 16-bit input shifter
// assumes all pins are asynchronous to clk_sys
`timescale 1ns/1ps
module afsc_serial_rx (
    input  wire logic   clk_sys,
    input  wire logic   rst,
    input  wire logic   sclk,
    input  wire logic   serial_in,
    input  wire logic   write_strobe,
    input  wire logic   chip_select_strap_low,
    input  wire logic   chip_select_strap_high,
    afsc_link_if.rx     link
);
    localparam int NPIN = 5;
    logic [NPIN-1:0] pin_raw;
    wire  [NPIN-1:0] pin_lvl;
    wire  [NPIN-1:0] pin_rise;
    logic [15:0]     shift;

    assign pin_raw = {chip_select_strap_high, chip_select_strap_low,
                      write_strobe, serial_in, sclk};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            logic [afsc_pkg::SYNC_LEN-1:0] stage;
            logic                          lvl;
            logic                          rise;
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    stage <= '0;
                end else begin
                    stage <= {stage[afsc_pkg::SYNC_LEN-2:0], pin_raw[g]};
                end
            end
            // a change counts only once stages two and three agree
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    lvl  <= 1'b0;
                    rise <= 1'b0;
                end else begin
                    rise <= 1'b0;
                    if (stage[1] == stage[2] && stage[2] != lvl) begin
                        lvl  <= stage[2];
                        rise <= stage[2];
                    end
                end
            end
            assign pin_lvl[g]  = lvl;
            assign pin_rise[g] = rise;
        end
    endgenerate

    // older bits fall off the top; only the last 16 survive
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shift <= 16'h0000;
        end else if (pin_rise[0]) begin
            shift <= {shift[14:0], pin_lvl[1]};
        end
    end

    assign link.sclk_rise   = pin_rise[0];
    assign link.strobe_rise = pin_rise[2];
    assign link.frame       = shift;
    assign link.strap       = pin_lvl[4:3];
endmodule : afsc_serial_rx

// ---- verif/afsc_host_model.sv ----
// host controller model driving the three-wire serial link
// assumes pins change at falling clk_sys; sclk idles low between frames
`timescale 1ns/1ps
module afsc_host_model (
    input  wire logic clk_sys,
    input  wire logic serial_read_out,
    output logic      sclk,
    output logic      serial_in,
    output logic      write_strobe
);
    initial begin
        sclk = 1'b0;
        serial_in = 1'b0;
        write_strobe = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : hold
    // five cycles a level: the bank filters pins over four
    task automatic put_bit(input logic b);
        serial_in = b;
        hold(5);
        sclk = 1'b1;
        hold(5);
        sclk = 1'b0;
    endtask : put_bit
    task automatic strobe();
        hold(5);
        write_strobe = 1'b1;
        hold(5);
        write_strobe = 1'b0;
        hold(8);
    endtask : strobe
    task automatic send(input logic [15:0] f);
        for (int i = 15; i >= 0; i--) put_bit(f[i]);
        // released data line must not keep its last level
        serial_in = ~serial_in;
        strobe();
    endtask : send
    task automatic fetch(input logic [15:0] f, input logic poke,
                         output logic [9:0] d);
        send(f);
        d[9] = serial_read_out;
        // resend f[5:0] so the poke strobe meets a well-formed write
        serial_in = f[5];
        hold(5);
        for (int i = 8; i >= -1; i--) begin
            sclk = 1'b1;
            hold(5);
            sclk = 1'b0;
            if (i >= 4) serial_in = f[i-4];
            hold(5);
            if (i >= 0) d[i] = serial_read_out;
            if (poke && i == 3) strobe();
        end
    endtask : fetch
endmodule : afsc_host_model

// ---- verif/afsc_regs_asserts.sv ----
// port checks of the register bank
// assumes the host holds each serial pin level five clk_sys cycles
`timescale 1ns/1ps
module afsc_regs_asserts (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       sclk,
    input  wire logic       write_strobe,
    input  wire logic       adc_bit_zero,
    input  wire logic       converter_clock,
    input  wire logic       serial_read_out,
    input  wire logic       standby_select,
    input  wire logic [3:0] edge2_delay,
    input  wire logic [3:0] edge1_delay,
    input  wire logic [9:0] even_gain,
    input  wire logic [9:0] odd_gain,
    input  wire logic [7:0] even_black_clamp,
    input  wire logic [7:0] odd_black_clamp,
    input  wire logic       test_enable,
    input  wire logic       pattern_select,
    input  wire logic [1:0] pattern_interval,
    input  wire logic       converter_clock_probe_enable,
    input  wire logic       output_bit_zero,
    input  wire logic       read_busy
);
    localparam logic [49:0] FIELDS_RST = {afsc_pkg::STANDBY_RST,
        afsc_pkg::EDGE2_RST, afsc_pkg::EDGE1_RST, afsc_pkg::GAIN_RST,
        afsc_pkg::GAIN_RST, afsc_pkg::CLAMP_RST, afsc_pkg::CLAMP_RST,
        afsc_pkg::TEST_EN_RST, afsc_pkg::PATTERN_RST,
        afsc_pkg::INTERVAL_RST, afsc_pkg::PROBE_RST};
    logic [49:0] fields;
    assign fields = {standby_select, edge2_delay, edge1_delay, even_gain,
        odd_gain, even_black_clamp, odd_black_clamp, test_enable,
        pattern_select, pattern_interval, converter_clock_probe_enable};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_reset_defaults: assert property (
        $past(rst) |-> fields == FIELDS_RST && !read_busy)
        else $error("fields not at defaults after reset");
    a_probe_route: assert property (
        !$past(rst) |-> output_bit_zero == ($past(converter_clock_probe_enable)
        ? $past(converter_clock) : $past(adc_bit_zero)))
        else $error("bit zero not routed as selected");
    a_read_blocks_write: assert property (
        read_busy |=> $stable(fields))
        else $error("register changed during readback");
    a_write_needs_strobe: assert property (
        !$past(rst) && $changed(fields) |-> write_strobe || $past(write_strobe))
        else $error("register changed without strobe");
    a_read_idle_low: assert property (
        !read_busy |-> !serial_read_out)
        else $error("read output active while idle");
    a_read_needs_strobe: assert property (
        $rose(read_busy) |-> write_strobe || $past(write_strobe))
        else $error("readback began without strobe");
    a_read_ends_sclk: assert property (
        $fell(read_busy) |-> sclk || $past(sclk))
        else $error("readback ended without serial clock");
    a_read_bit_sclk: assert property (
        $changed(serial_read_out) && read_busy && $past(read_busy)
        |-> sclk || $past(sclk))
        else $error("read bit moved without serial clock");
    a_read_min_span: assert property (
        $rose(read_busy) |-> read_busy [*8])
        else $error("readback too short");
endmodule : afsc_regs_asserts
bind afsc_regs afsc_regs_asserts i_chk (.clk_sys, .rst, .sclk,
    .write_strobe, .adc_bit_zero, .converter_clock, .serial_read_out,
    .standby_select, .edge2_delay, .edge1_delay, .even_gain, .odd_gain,
    .even_black_clamp, .odd_black_clamp, .test_enable, .pattern_select,
    .pattern_interval, .converter_clock_probe_enable, .output_bit_zero,
    .read_busy);

// ---- verif/tb.sv ----
// testbench: register bank driven through the host link model
// assumes the host model owns the serial pins; straps fixed at 2
`timescale 1ns/1ps
module tb;
    localparam logic [1:0] CHIP = 2'h2;
    localparam logic [9:0] RV [8] = '{10'h000, 10'h220, 10'h040, 10'h040,
                                      10'h050, 10'h050, 10'h000, 10'h000};
    localparam logic [9:0] WV [8] = '{10'h3FF, 10'h3C7, 10'h3FF, 10'h001,
                                      10'h3AB, 10'h3FF, 10'h3FF, 10'h3FF};
    localparam logic [9:0] BV [8] = '{10'h000, 10'h3C5, 10'h3FF, 10'h001,
                                      10'h0AB, 10'h0FF, 10'h035, 10'h002};
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       converter_clock = 1'b0;
    logic       adc_bit_zero = 1'b0;
    logic       chip_select_strap_low = CHIP[0];
    logic       chip_select_strap_high = CHIP[1];
    logic       sclk, serial_in, write_strobe, serial_read_out;
    logic       standby_select, test_enable, pattern_select, read_busy;
    logic       converter_clock_probe_enable, output_bit_zero;
    logic [3:0] edge2_delay, edge1_delay;
    logic [9:0] even_gain, odd_gain, rd_val;
    logic [7:0] even_black_clamp, odd_black_clamp;
    logic [1:0] pattern_interval;
    int         err_total = 0;
    int         comparisons = 0;
    always #20 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        converter_clock <= ~converter_clock;
        adc_bit_zero <= converter_clock;
    end
    afsc_regs i_dut (.clk_sys, .rst, .sclk, .serial_in, .write_strobe,
        .chip_select_strap_low, .chip_select_strap_high, .adc_bit_zero,
        .converter_clock, .serial_read_out, .standby_select, .edge2_delay,
        .edge1_delay, .even_gain, .odd_gain, .even_black_clamp,
        .odd_black_clamp, .test_enable, .pattern_select, .pattern_interval,
        .converter_clock_probe_enable, .output_bit_zero, .read_busy);
    afsc_host_model i_host (.clk_sys, .serial_read_out, .sclk, .serial_in,
        .write_strobe);
    task automatic check(input logic [19:0] seen, input logic [19:0] want);
        comparisons++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [9:0] d);
        i_host.send({CHIP, 1'b0, a, d});
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic poke,
                      input logic [9:0] want);
        logic [9:0] tail;
        // with poke, tail plus six resent bits form a write to odd_gain
        tail = poke ? {CHIP, 1'b0, afsc_pkg::ADDR_OGAIN, 4'h5} : 10'h000;
        i_host.fetch({CHIP, 1'b1, a, tail}, poke, rd_val);
        check(rd_val, want);
    endtask : rd
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        check(even_gain, afsc_pkg::GAIN_RST);
        check(odd_black_clamp, afsc_pkg::CLAMP_RST);
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], 1'b0, RV[a]);
        end
        // edge1 code F lands later than edge2 code 1 and is still stored
        for (int a = 0; a < 8; a++) begin
            wr(a[2:0], WV[a]);
            rd(a[2:0], 1'b0, BV[a]);
        end
        check({edge1_delay, edge2_delay, standby_select}, 9'h1E3);
        check(even_black_clamp, 8'hAB);
        check(converter_clock_probe_enable, 1'b1);
        check(output_bit_zero, converter_clock);
        for (int c = 0; c < 4; c++) begin
            wr(afsc_pkg::ADDR_TEST, {4'h0, c[1:0], 1'b0, c[0], 1'b0, ~c[0]});
            check({pattern_interval, pattern_select, test_enable},
                  {c[1:0], c[0], ~c[0]});
        end
        i_host.send({2'h1, 1'b0, afsc_pkg::ADDR_EGAIN, 10'h155});
        check(even_gain, 10'h3FF);
        repeat (4) i_host.put_bit(1'b1);
        wr(afsc_pkg::ADDR_OGAIN, 10'h2AA);
        check(odd_gain, 10'h2AA);
        rd(afsc_pkg::ADDR_EGAIN, 1'b1, 10'h3FF);
        check({even_gain, odd_gain}, {10'h3FF, 10'h2AA});
        wr(afsc_pkg::ADDR_PROBE, 10'h000);
        check(converter_clock_probe_enable, 1'b0);
        check(output_bit_zero, adc_bit_zero);
        // second reset in mid-run must bring back every default
        rst = 1'b1;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        check({even_gain, odd_gain},
              {afsc_pkg::GAIN_RST, afsc_pkg::GAIN_RST});
        rd(afsc_pkg::ADDR_ECLAMP, 1'b0, RV[4]);
        stop_test();
    end
    // full run needs about 0.31 ms; over six times that marks a hang
    initial begin
        #2_000_000;
        err_total++;
        stop_test();
    end
endmodule : tb
